//--- verilog/sdr_consts.svh
// Purpose: shared numeric constants of the receive path
// Assumes: included by bare name from the receive module only
// Notes:   definitions only
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH
`define SDR_CRC_PRESET   16'hFFFF
`define SDR_CRC_POLY     16'h1021
`define SDR_CRC_GOOD     16'h1D0F
`define SDR_GLOBAL_ADDR  8'hFF
`define SDR_STUFF_ONES   3'h5
`define SDR_ABORT_PRE    3'h6
`define SDR_ONES_MAX     3'h7
`define SDR_LEN_BASE     4'h5
`define SDR_DLY_FULL     3'h7
`endif

//--- verilog/sdr_pkg.sv
// Purpose: types shared by the receive path
// Assumes: nothing beyond the constants header
// Notes:   every code written out
`default_nettype none
package sdr_pkg;
	// link framing states, one-hot
	typedef enum logic [3:0] {
		SDR_HUNT = 4'h1,
		SDR_ADDR = 4'h2,
		SDR_DATA = 4'h4,
		SDR_SKIP = 4'h8
	} sdr_state_t;
	// receive interrupt handling
	typedef enum logic [1:0] {
		SDR_INT_NONE    = 2'h0,
		SDR_INT_FIRST   = 2'h1,
		SDR_INT_EVERY_P = 2'h2,
		SDR_INT_EVERY   = 2'h3
	} sdr_int_mode_t;
	// vector the host sees when status modifies it
	typedef enum logic [1:0] {
		SDR_VEC_NONE    = 2'h0,
		SDR_VEC_CHAR    = 2'h1,
		SDR_VEC_SPECIAL = 2'h2,
		SDR_VEC_EXT     = 2'h3
	} sdr_vec_t;
	// one receive FIFO word: character and its status
	typedef struct packed {
		logic [7:0] data;
		logic       eof;
		logic       crc_err;
		logic [2:0] residue;
	} sdr_entry_t;
	// receive configuration carried into the link domain
	typedef struct packed {
		logic       enable;
		logic       addr_search;
		logic [1:0] char_len;
		logic [7:0] flag_pattern_register;
		logic [7:0] secondary_address_register;
	} sdr_cfg_t;
	typedef struct packed {
		logic carrier;
		logic break_abort;
		logic rx_avail;
	} sdr_primary_t;
	typedef struct packed {
		logic       eof;
		logic       crc_err;
		logic [2:0] residue;
		logic       overrun;
	} sdr_cond_t;
endpackage
`default_nettype wire

//--- verilog/sdr_rx.sv
// Purpose: bit-oriented synchronous receive path, one channel
// Assumes: rx_data changes with rx_clk; controls are on mclk
// Notes:   link framing on rx_clk, FIFO and interrupts on mclk
`timescale 1ns/100ps
`default_nettype none
`include "sdr_consts.svh"

// Operation
// - after opening flag, each complete character goes to FIFO with its status
// - receive interrupts selectable: none, first character only, every character
// - first-character mode interrupts once, then only special; wait/ready paces host
// - next-character command re-arms first-character interrupt
// - carrier-detect change raises external/status interrupt when enabled
// - every-character mode interrupts while FIFO holds data; special vector distinct
// - special receive interrupt only when a receive interrupt mode is selected
// - overrun and end-of-frame are the special receive conditions
// - overrun bit is sticky and cleared only by error reset
// - end-of-frame set only on closing flag, CRC error and residue valid then
// - character length change applies if made before old count reached
// - CRC checker runs alone, reset by opening flag, covers all bits
// - CRC result reported with end-of-frame character, error clear when valid
// - frame good only when remainder equals 1D0F
// - two CRC bytes go to FIFO as ordinary data
// - closing flag produces special vector marking end-of-frame character
// - residue code valid at end-of-frame gives partial character boundary
// - seven ones is abort: break/abort set, external interrupt if enabled
// - end of continuous ones raises second external interrupt
// - CRC covers every character, no delay, complete with second CRC byte
// - flags found by matching programmed flag pattern register
// - address search accepts frame on secondary or global address match
// - global address is hardwired all ones
// - hunt until first flag; re-enter hunt only by host command or clearing enable
// - inserted zeros removed, flags never reach FIFO
module sdr_rx
	import sdr_pkg::*;
#(
	parameter int DEPTH = 3
) (
	// system clock and reset
	input  wire logic          mclk,
	input  wire logic          rst_n,
	// serial link from the remote station
	input  wire logic          rx_clk,
	input  wire logic          rx_data,
	input  wire logic          carrier_detect_input,
	// configuration levels
	input  wire sdr_cfg_t      receive_control_register,
	input  wire sdr_int_mode_t interrupt_control_register,
	input  wire logic          status_vec_en,
	input  wire logic          ext_int_en,
	input  wire logic          wait_ready_en,
	// host commands, one-cycle pulses
	input  wire logic          cmd_hunt,
	input  wire logic          cmd_int_next_char,
	input  wire logic          cmd_error_reset,
	input  wire logic          cmd_reset_ext,
	// receive FIFO read side
	input  wire logic          rd_en,
	output logic               rd_valid,
	output sdr_entry_t         rd_entry,
	// status
	output sdr_primary_t       primary_status_register,
	output sdr_cond_t          receive_condition_status_register,
	// interrupt requests
	output logic               rx_int,
	output logic               ext_int,
	output sdr_vec_t           int_vector,
	output logic               wait_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	// link-domain reset, released on rx_clk
	logic lrst_s1;
	logic lrst_n_q;
	always_ff @(posedge rx_clk) begin
		lrst_s1  <= rst_n;
		lrst_n_q <= lrst_s1;
	end

	// configuration handshake, mclk side: a word moves only while idle
	sdr_cfg_t cfg_hold_q;
	logic     cfg_req_q;
	logic     ack_s1;
	logic     ack_s2;
	logic     cfg_ack_q;
	always_ff @(posedge mclk) begin
		ack_s1 <= cfg_ack_q;
		ack_s2 <= ack_s1;
		if (!rst_n) begin
			cfg_hold_q <= '0;
			cfg_req_q  <= 1'b0;
		end else if (cfg_req_q == ack_s2 && receive_control_register != cfg_hold_q) begin
			cfg_hold_q <= receive_control_register;
			cfg_req_q  <= ~cfg_req_q;
		end
	end

	// hunt command becomes a toggle for the link domain
	logic hunt_tgl_q;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			hunt_tgl_q <= 1'b0;
		else if (cmd_hunt)
			hunt_tgl_q <= ~hunt_tgl_q;
	end

	// link side of both crossings
	sdr_cfg_t cfg_l_q;
	logic     req_s1;
	logic     req_s2;
	logic     hs1;
	logic     hs2;
	logic     hs3;
	always_ff @(posedge rx_clk) begin
		req_s1 <= cfg_req_q;
		req_s2 <= req_s1;
		hs1    <= hunt_tgl_q;
		hs2    <= hs1;
		if (!lrst_n_q) begin
			cfg_l_q   <= '0;
			cfg_ack_q <= 1'b0;
			hs3       <= 1'b0;
		end else begin
			hs3 <= hs2;
			if (req_s2 != cfg_ack_q) begin
				cfg_l_q   <= cfg_hold_q;
				cfg_ack_q <= req_s2;
			end
		end
	end

	// raw bit decode: flag match, stuffed zero, seventh one
	sdr_state_t  st_q;
	logic [7:0]  sh_q;
	logic [2:0]  ones_q;
	logic [6:0]  dly_q;
	logic [2:0]  dcnt_q;
	logic [7:0]  asm_q;
	logic [2:0]  acnt_q;
	logic [15:0] crc_q;
	logic        abort_l_q;
	sdr_entry_t  ch_hold_q;
	logic        ch_tgl_q;
	wire  [7:0]  raw_win   = {sh_q[6:0], rx_data};
	wire         flag_hit  = raw_win == cfg_l_q.flag_pattern_register;
	wire         stuff     = ones_q == `SDR_STUFF_ONES && !rx_data;
	wire         abort_hit = ones_q == `SDR_ABORT_PRE && rx_data;
	wire         in_frame  = st_q == SDR_ADDR || st_q == SDR_DATA;
	wire         push_bit  = in_frame && !stuff && !flag_hit && !abort_hit;
	wire         bit_out   = push_bit && dcnt_q == `SDR_DLY_FULL;
	wire         ob        = dly_q[6];
	wire  [3:0]  len       = `SDR_LEN_BASE + {2'h0, cfg_l_q.char_len};
	wire  [7:0]  asm_d     = {ob, asm_q[7:1]};
	wire         ch_done   = ({1'b0, acnt_q} + 4'h1) >= len;
	wire  [7:0]  ch_data   = asm_d >> (4'h8 - len);
	wire         addr_ok   = !cfg_l_q.addr_search
	                         || ch_data == cfg_l_q.secondary_address_register
	                         || ch_data == `SDR_GLOBAL_ADDR;
	wire         crc_fb    = crc_q[15] ^ ob;
	wire  [15:0] crc_d     = {crc_q[14:0], 1'b0} ^ (crc_fb ? `SDR_CRC_POLY : 16'h0000);

	// raw history and run of ones
	always_ff @(posedge rx_clk) begin
		if (!lrst_n_q) begin
			sh_q      <= 8'h00;
			ones_q    <= 3'h0;
			abort_l_q <= 1'b0;
		end else begin
			sh_q   <= raw_win;
			ones_q <= !rx_data ? 3'h0 : (ones_q == `SDR_ONES_MAX ? ones_q : ones_q + 3'h1);
			if (abort_hit)
				abort_l_q <= 1'b1;
			else if (!rx_data)
				abort_l_q <= 1'b0;
		end
	end

	// framing state; abort or rejected address waits for a flag, never hunt
	always_ff @(posedge rx_clk) begin
		if (!lrst_n_q || !cfg_l_q.enable)
			st_q <= SDR_HUNT;
		else if (hs2 != hs3)
			st_q <= SDR_HUNT;
		else if (flag_hit)
			st_q <= SDR_ADDR;
		else if (abort_hit && in_frame)
			st_q <= SDR_SKIP;
		else if (bit_out && ch_done && st_q == SDR_ADDR)
			st_q <= addr_ok ? SDR_DATA : SDR_SKIP;
		else
			st_q <= st_q;
	end

	// seven-bit delay keeps flag bits out of the character path
	always_ff @(posedge rx_clk) begin
		if (!lrst_n_q || flag_hit || !in_frame) begin
			dly_q  <= 7'h00;
			dcnt_q <= 3'h0;
		end else if (push_bit) begin
			dly_q  <= {dly_q[5:0], rx_data};
			dcnt_q <= dcnt_q == `SDR_DLY_FULL ? dcnt_q : dcnt_q + 3'h1;
		end
	end

	// character assembly, LSB first; CRC over every delivered bit
	always_ff @(posedge rx_clk) begin
		if (!lrst_n_q || flag_hit || !in_frame) begin
			asm_q  <= 8'h00;
			acnt_q <= 3'h0;
			crc_q  <= `SDR_CRC_PRESET;
		end else if (bit_out) begin
			crc_q  <= crc_d;
			asm_q  <= ch_done ? 8'h00 : asm_d;
			acnt_q <= ch_done ? 3'h0 : acnt_q + 3'h1;
		end
	end

	// hand characters and end-of-frame words to the mclk domain
	always_ff @(posedge rx_clk) begin
		if (!lrst_n_q) begin
			ch_hold_q <= '0;
			ch_tgl_q  <= 1'b0;
		end else if (flag_hit && st_q == SDR_DATA) begin
			ch_hold_q.data    <= asm_q >> (4'h8 - {1'b0, acnt_q});
			ch_hold_q.eof     <= 1'b1;
			ch_hold_q.crc_err <= crc_q != `SDR_CRC_GOOD;
			ch_hold_q.residue <= acnt_q;
			ch_tgl_q          <= ~ch_tgl_q;
		end else if (bit_out && ch_done && (st_q == SDR_DATA || addr_ok)) begin
			ch_hold_q.data    <= ch_data;
			ch_hold_q.eof     <= 1'b0;
			ch_hold_q.crc_err <= 1'b0;
			ch_hold_q.residue <= 3'h0;
			ch_tgl_q          <= ~ch_tgl_q;
		end
	end

	// mclk synchronisers: character toggle, abort level, carrier
	logic cs1;
	logic cs2;
	logic cs3;
	logic as1;
	logic as2;
	logic as3;
	logic ds1;
	logic ds2;
	logic ds3;
	always_ff @(posedge mclk) begin
		cs1 <= ch_tgl_q;
		as1 <= abort_l_q;
		ds1 <= carrier_detect_input;
		if (!rst_n) begin
			cs2 <= 1'b0;
			cs3 <= 1'b0;
			as2 <= 1'b0;
			as3 <= 1'b0;
			ds2 <= 1'b0;
			ds3 <= 1'b0;
		end else begin
			cs2 <= cs1;
			cs3 <= cs2;
			as2 <= as1;
			as3 <= as2;
			ds2 <= ds1;
			ds3 <= ds2;
		end
	end

	// receive FIFO in flops; a word arriving while full is dropped unless a read pops in the same cycle
	sdr_entry_t    mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	wire           ch_pulse = cs2 ^ cs3;
	wire           pop      = rd_en && cnt_q != '0;
	wire           push     = ch_pulse && (cnt_q != FULL || pop);
	wire           overrun  = ch_pulse && !push;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= ch_hold_q;
				wp_q        <= wp_q == LAST ? '0 : wp_q + 1'b1;
			end
			if (pop)
				rp_q <= rp_q == LAST ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	// sticky overrun, set wins over error reset
	logic ovr_q;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ovr_q <= 1'b0;
		else if (overrun)
			ovr_q <= 1'b1;
		else if (cmd_error_reset)
			ovr_q <= 1'b0;
	end

	// receive interrupt sources
	logic first_arm_q;
	logic first_pend_q;
	logic spec_q;
	wire  mode_on  = interrupt_control_register != SDR_INT_NONE;
	wire  every    = interrupt_control_register[1];
	wire  spec_set = mode_on && (overrun || (push && ch_hold_q.eof));
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			first_arm_q  <= 1'b1;
			first_pend_q <= 1'b0;
			spec_q       <= 1'b0;
		end else begin
			if (push && interrupt_control_register == SDR_INT_FIRST && first_arm_q)
				first_arm_q <= 1'b0;
			else if (cmd_int_next_char)
				first_arm_q <= 1'b1;
			if (push && interrupt_control_register == SDR_INT_FIRST && first_arm_q)
				first_pend_q <= 1'b1;
			else if (pop || !mode_on)
				first_pend_q <= 1'b0;
			if (spec_set)
				spec_q <= 1'b1;
			else if (cmd_error_reset || !mode_on)
				spec_q <= 1'b0;
		end
	end

	// external/status: carrier change and abort start or end; set wins
	logic ext_pend_q;
	wire  ext_ev = (ds2 ^ ds3) || (as2 ^ as3);
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ext_pend_q <= 1'b0;
		else if (ext_int_en && ext_ev)
			ext_pend_q <= 1'b1;
		else if (cmd_reset_ext)
			ext_pend_q <= 1'b0;
	end

	// request and vector outputs; special outranks a plain character
	assign rx_int     = mode_on && (spec_q || first_pend_q || (every && cnt_q != '0));
	assign ext_int    = ext_pend_q;
	assign wait_ready = wait_ready_en && cnt_q != '0;
	always_comb begin
		int_vector = SDR_VEC_NONE;
		if (status_vec_en) begin
			if (mode_on && spec_q)
				int_vector = SDR_VEC_SPECIAL;
			else if (rx_int)
				int_vector = SDR_VEC_CHAR;
			else if (ext_pend_q)
				int_vector = SDR_VEC_EXT;
		end
	end

	// status views of the FIFO head, carrier, abort level and sticky overrun
	assign rd_valid = cnt_q != '0;
	assign rd_entry = mem_q[rp_q];
	assign primary_status_register = '{carrier: ds3, break_abort: as3, rx_avail: rd_valid};
	assign receive_condition_status_register = '{eof: rd_entry.eof, crc_err: rd_entry.crc_err,
	                                             residue: rd_entry.residue, overrun: ovr_q};

	// checks on the mclk side
	a_ovr_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		ovr_q && !cmd_error_reset |=> ovr_q) else $error("overrun lost");
	a_ovr_set: assert property (@(posedge mclk) disable iff (!rst_n)
		overrun |=> ovr_q) else $error("overrun not latched");
	a_spec_none: assert property (@(posedge mclk) disable iff (!rst_n)
		interrupt_control_register == SDR_INT_NONE |-> !rx_int ##1 (!spec_q && !first_pend_q))
		else $error("receive interrupt with mode none");
	a_every_char: assert property (@(posedge mclk) disable iff (!rst_n)
		every && rd_valid |-> rx_int) else $error("every-char interrupt missing");
	a_eof_special: assert property (@(posedge mclk) disable iff (!rst_n)
		push && ch_hold_q.eof && mode_on |=> spec_q ##0 rx_int)
		else $error("end-of-frame without special");
	a_ext_carrier: assert property (@(posedge mclk) disable iff (!rst_n)
		ext_int_en && (ds2 != ds3) |=> ext_int) else $error("carrier change missed");
	a_first_once: assert property (@(posedge mclk) disable iff (!rst_n)
		interrupt_control_register == SDR_INT_FIRST && !first_arm_q && !cmd_int_next_char
		|=> !first_arm_q) else $error("first-char rearmed alone");
	a_wait_data: assert property (@(posedge mclk) disable iff (!rst_n)
		wait_ready |-> rd_valid) else $error("ready with empty fifo");

	// checks on the link side
	a_abort_seen: assert property (@(posedge rx_clk) disable iff (!lrst_n_q)
		ones_q == `SDR_ABORT_PRE && rx_data |=> abort_l_q [*1] ##0 ones_q == `SDR_ONES_MAX)
		else $error("abort not flagged");
	a_hunt_hold: assert property (@(posedge rx_clk) disable iff (!lrst_n_q)
		st_q == SDR_HUNT && !flag_hit && hs2 == hs3 |=> st_q == SDR_HUNT)
		else $error("left hunt without flag");
	a_crc_preset: assert property (@(posedge rx_clk) disable iff (!lrst_n_q)
		flag_hit |=> crc_q == `SDR_CRC_PRESET) else $error("crc not preset");
endmodule
`default_nettype wire

//--- dv/sdr_station.sv
// Purpose: remote station model driving the serial receive line
// Assumes: bits change on the falling edge of the link clock
// Notes:   line is filled with flags between frames, so it never idles as ones
`timescale 1ns/100ps
`default_nettype none
module sdr_station (
	// serial link towards the receiver
	output var logic rx_clk,
	output var logic rx_data
);
	logic        bq[$];
	logic        dbits[$];
	logic [15:0] crc;
	int          ones;

	// link clock runs free at 15 ns; the receiver needs it during reset too
	initial begin
		rx_clk = 1'b0;
		#3.3;
		forever #7.5 rx_clk = ~rx_clk;
	end

	// idle fill with flags keeps the receiver framed and never looks like an abort
	initial rx_data = 1'b1;
	always @(negedge rx_clk) begin
		if (bq.size() == 0)
			raw(8'h7E, 8);
		rx_data <= bq.pop_front();
	end

	// raw bits, no stuffing: flags and abort runs
	task automatic raw(input logic [7:0] b, input int n);
		int i;
		for (i = 0; i < n; i++)
			bq.push_back(b[i]);
	endtask

	// zero inserted after five ones so data never mimics a flag
	task automatic tx(input logic d);
		dbits.push_back(d);
		bq.push_back(d);
		ones = d ? ones + 1 : 0;
		if (ones == 5) begin
			bq.push_back(1'b0);
			ones = 0;
		end
	endtask

	// data bits, lsb first, folded into the check sequence
	task automatic put(input logic [7:0] b, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? 16'h1021 : 16'h0000);
			tx(b[i]);
		end
	endtask

	task automatic open_frame;
		raw(8'h7E, 8);
		crc = 16'hFFFF;
		ones = 0;
		dbits.delete();
	endtask

	// check sequence sent inverted, msb first; bad flips its last bit
	task automatic close_frame(input logic bad);
		logic [15:0] c;
		int          i;
		c = ~crc ^ {15'h0000, bad};
		for (i = 15; i >= 0; i--)
			tx(c[i]);
		raw(8'h7E, 8);
	endtask

	// sixteen ones in a row, then flags resume and end the abort
	task automatic abort_frame;
		raw(8'h7E, 8);
		raw(8'hFF, 8);
		raw(8'hFF, 8);
	endtask
endmodule
`default_nettype wire

//--- dv/sdr_rx_test.sv
// Purpose: self-checking bench of the serial receive path
// Assumes: station model drives the line; host side is driven here
// Notes:   expected words come from the station's own record of data bits
`timescale 1ns/100ps
`default_nettype none
module sdr_rx_test
	import sdr_pkg::*;
;
	logic          mclk, rst_n, carrier, rx_clk, rx_data;
	logic          rd_valid, rx_int, ext_int, wait_ready;
	logic          sv_en, xi_en, wr_en;
	logic [4:0]    cmd;
	sdr_cfg_t      cfg;
	sdr_int_mode_t imode;
	sdr_entry_t    rd_entry;
	sdr_primary_t  prim;
	sdr_cond_t     cond;
	sdr_vec_t      vec;
	int            miscompares, n_tests, wd, clen;

	// cmd bits: 0 hunt, 1 next char, 2 error reset, 3 reset ext, 4 read
	sdr_rx #(.DEPTH(3)) DUT (
		.mclk                             (mclk),
		.rst_n                            (rst_n),
		.rx_clk                           (rx_clk),
		.rx_data                          (rx_data),
		.carrier_detect_input             (carrier),
		.receive_control_register         (cfg),
		.interrupt_control_register       (imode),
		.status_vec_en                    (sv_en),
		.ext_int_en                       (xi_en),
		.wait_ready_en                    (wr_en),
		.cmd_hunt                         (cmd[0]),
		.cmd_int_next_char                (cmd[1]),
		.cmd_error_reset                  (cmd[2]),
		.cmd_reset_ext                    (cmd[3]),
		.rd_en                            (cmd[4]),
		.rd_valid                         (rd_valid),
		.rd_entry                         (rd_entry),
		.primary_status_register          (prim),
		.receive_condition_status_register(cond),
		.rx_int                           (rx_int),
		.ext_int                          (ext_int),
		.int_vector                       (vec),
		.wait_ready                       (wait_ready)
	);
	sdr_station STN (
		.rx_clk (rx_clk),
		.rx_data(rx_data)
	);

	// system clock, 5 ns
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	// hang guard, far above the few thousand cycles the sequence needs
	always @(posedge mclk) begin
		wd <= wd + 1;
		if (wd == 30000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// sample one ns after the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic pulse(input int i);
		@(posedge mclk);
		cmd[i] <= 1'b1;
		@(posedge mclk);
		cmd <= 5'h00;
		tick(1);
	endtask

	task automatic wait_rd;
		while (rd_valid !== 1'b1)
			tick(1);
	endtask

	task automatic pop(input sdr_entry_t e);
		wait_rd();
		chk(rd_entry, e);
		pulse(4);
	endtask

	// word w of the frame: full characters, then the end word with the leftover bits
	function automatic sdr_entry_t word(input int w, input logic bad);
		int         n, k;
		logic [7:0] b;
		n = STN.dbits.size();
		b = 8'h00;
		for (k = 0; k < clen && w * clen + k < n; k++)
			b[k] = STN.dbits[w * clen + k];
		if ((w + 1) * clen <= n)
			return {b, 5'h00};
		return {b, 1'b1, bad, 3'(n - w * clen)};
	endfunction

	task automatic drain(input logic bad, input int from);
		int w;
		for (w = from; w <= STN.dbits.size() / clen; w++)
			pop(word(w, bad));
	endtask

	task automatic send(input logic [31:0] b, input int nb, input logic bad);
		int i;
		STN.open_frame();
		for (i = 0; i < nb; i++)
			STN.put(b[8 * i +: 8], 8);
		STN.close_frame(bad);
	endtask

	// main sequence; reset spans enough link edges for its synchroniser
	initial begin
		rst_n = 1'b0;
		carrier = 1'b0;
		cmd = 5'h00;
		wd = 0;
		clen = 8;
		sv_en = 1'b1;
		xi_en = 1'b1;
		wr_en = 1'b1;
		miscompares = 0;
		n_tests = 0;
		cfg = {1'b1, 1'b0, 2'h3, 8'h7E, 8'h5A};
		imode = SDR_INT_EVERY;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		tick(200);
		chk(rd_valid, 1'b0);
		carrier <= 1'b1;
		tick(8);
		chk(ext_int, 1'b1);
		chk(prim.carrier, 1'b1);
		chk(vec, SDR_VEC_EXT);
		pulse(3);
		chk(ext_int, 1'b0);
		// with external/status interrupts off a carrier change leaves nothing pending
		xi_en <= 1'b0;
		carrier <= 1'b0;
		tick(8);
		chk(ext_int, 1'b0);
		chk(prim.carrier, 1'b0);
		xi_en <= 1'b1;
		send(32'h3C7EFF5A, 4, 1'b0);
		wait_rd();
		chk(rx_int, 1'b1);
		drain(1'b0, 0);
		chk(vec, SDR_VEC_SPECIAL);
		sv_en <= 1'b0;
		tick(1);
		chk(vec, SDR_VEC_NONE);
		sv_en <= 1'b1;
		pulse(2);
		chk(rx_int, 1'b0);
		// partial last character and a corrupted check sequence
		imode <= SDR_INT_EVERY_P;
		STN.open_frame();
		STN.put(8'h81, 8);
		STN.put(8'h05, 3);
		STN.close_frame(1'b1);
		drain(1'b1, 0);
		pulse(2);
		// first frame has a foreign address and must vanish
		cfg.addr_search <= 1'b1;
		tick(100);
		send(32'h1133, 2, 1'b0);
		send(32'h22FF, 2, 1'b0);
		drain(1'b0, 0);
		send(32'h445A, 2, 1'b0);
		drain(1'b0, 0);
		cfg.addr_search <= 1'b0;
		imode <= SDR_INT_FIRST;
		pulse(2);
		pulse(1);
		tick(100);
		send(32'h332211, 3, 1'b0);
		wait_rd();
		chk(rx_int, 1'b1);
		chk(vec, SDR_VEC_CHAR);
		chk(wait_ready, 1'b1);
		wr_en <= 1'b0;
		tick(1);
		chk(wait_ready, 1'b0);
		wr_en <= 1'b1;
		pop(word(0, 1'b0));
		wait_rd();
		chk(rx_int, 1'b0);
		drain(1'b0, 1);
		chk(rx_int, 1'b1);
		pulse(2);
		pulse(1);
		send(32'h66, 1, 1'b0);
		wait_rd();
		chk(rx_int, 1'b1);
		drain(1'b0, 0);
		pulse(2);
		// polled mode, nobody reads: the fifo overflows
		imode <= SDR_INT_NONE;
		// hunt command mid-frame drops the rest of that frame
		send(32'h77665544, 4, 1'b0);
		wait_rd();
		pulse(0);
		pop(word(0, 1'b0));
		tick(300);
		chk(rd_valid, 1'b0);
		// seven-bit characters leave a four-bit residue at the closing flag
		cfg.char_len <= 2'h2;
		clen = 7;
		tick(100);
		send(32'h2211, 2, 1'b0);
		drain(1'b0, 0);
		cfg.char_len <= 2'h3;
		clen = 8;
		tick(100);
		send(32'h44332211, 4, 1'b0);
		tick(600);
		chk(cond.overrun, 1'b1);
		chk(rx_int, 1'b0);
		repeat (3) pulse(4);
		chk(cond.overrun, 1'b1);
		pulse(2);
		chk(cond.overrun, 1'b0);
		STN.abort_frame();
		while (prim.break_abort !== 1'b1)
			tick(1);
		chk(ext_int, 1'b1);
		pulse(3);
		chk(ext_int, 1'b0);
		while (ext_int !== 1'b1)
			tick(1);
		chk(prim.break_abort, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
